// file: rtl/system_config_regs_16_to_1f.sv
// System configuration registers 16h-1Fh and their decoded controls
// Overview of operation
// - Tag bit 5 clear selects 8-bit tag on dirty pin; set selects 7-bit on chip select.
// - Tag bit 4 sets combined dirty/tag single write hit leadoff: 5 or 4.
// - Tag bit 3 clear pre-snoops address 0 only; set skips line boundaries.
// - Tag bit 0 set drops host data output enable one clock early.
// - Cycle register bit 0 picks interleaved (0) or linear (1) burst order.
// - Cycle register bit 6 with async PCI clock issues next address on PCI slave access.
// - Decode register 3 holds bank 4 enable at bit 3 and size; 000 means empty.
// - Decode register 3 bit 7 makes shared pin global write enable or bank 5 row strobe.
// - Shadow 1 bits 6:5 guarantee CPU 0, 1, 2 or 4 us per 15 us.
// - Shadow 1 bit 4 picks 16KB or 8KB granularity; fine fields only apply when set.
// - Two-bit shadow fields route segment reads and writes between PCI and DRAM.
// - EDO register bits 7:2 mark banks 5 to 0 as EDO when set.
// - EDO bit 0 gives one-clock column strobe for CPU read bursts to EDO banks.
// - EDO bit 1 permits X-2-2-2 bursts on fast-page parts at slow clocks.
// - In SMM, misc 3 bits 1 and 0 send A and B segments to PCI.
// - Misc 3 bit 3 blocks DMA from memory; bit 4 shortens read leadoff.
// - Bridge bit 7 lets target ready go without waiting for initiator ready.
// - Bridge bit 3 asserts CPU back-off on bridge deadlock retry.
// - Bridge bits 4 and 3 assert back-off on retries in 80000h-FFFFFh.
// - Bridge bit 1 disables PCI burst when byte enable halves are not all zero.
// - Timing bit 0 makes D0000h-DFFFFh cacheable without write protection.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "sysconf_defs.svh"
module system_config_regs_16_to_1f
    import sysconf_pkg::*;
#(
    parameter int LINE_BITS = 5
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [7:0] rdata_o,
    // Cache tag control
    output logic tag_is_7bit_o,
    output logic cache_chip_select_pin_en_o,
    output logic dirty_pin_en_o,
    output logic [2:0] write_hit_leadoff_o,
    // Pre-snoop
    input wire logic snoop_start_i,
    input wire logic [31:0] snoop_addr_i,
    output logic presnoop_req_o,
    // Host data output enable
    input wire logic host_cycle_active_i,
    input wire logic host_cycle_last_clk_i,
    output logic host_data_out_enable_o,
    // Host burst and next address
    output logic linear_burst_o,
    output logic pci_clock_sync_o,
    input wire logic cpu_pci_slave_access_i,
    output logic next_address_request_o,
    // DRAM bank decode
    output logic bank4_enable_o,
    output logic [2:0] bank4_size_o,
    output logic bank4_populated_o,
    output logic pin_is_row_strobe_bank_five_o,
    output logic global_write_enable_pin_en_o,
    // CPU bandwidth guarantee
    output logic cpu_bus_guaranteed_o,
    // Shadowing
    input wire logic [19:0] mem_addr_i,
    input wire logic mem_write_i,
    output logic shadow_fine_8k_o,
    output logic shadow_seg_hit_o,
    output logic shadow_to_dram_o,
    // EDO
    input wire logic [2:0] burst_bank_i,
    input wire logic cpu_read_burst_i,
    output logic [5:0] bank_is_edo_o,
    output logic cas_one_clk_o,
    output logic fpm_fast_burst_o,
    // SMM and misc
    input wire logic smm_active_i,
    output logic smm_route_to_pci_o,
    output logic dma_from_memory_blocked_o,
    output logic dram_leadoff_cut_o,
    // PCI bridge handling
    input wire logic pci_master_read_i,
    input wire logic pci_irdy_i,
    output logic pci_trdy_allowed_o,
    input wire logic bridge_deadlock_i,
    input wire logic pci_retry_i,
    input wire logic [31:0] pci_retry_addr_i,
    output logic cpu_back_off_o,
    input wire logic [7:0] host_be_n_i,
    output logic pci_burst_disable_o,
    output logic d_region_cacheable_o
);
    cfg_if cfg ();

    cfg_store u_store (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .we_i(we_i),
        .re_i(re_i),
        .rdata_o(rdata_o),
        .cfg(cfg.store)
    );

    logic seg_hit;
    logic seg_dram;

    shadow_route u_shadow (
        .cfg(cfg.use_side),
        .seg_addr_i(mem_addr_i[19:13]),
        .is_write_i(mem_write_i),
        .seg_hit_o(seg_hit),
        .to_dram_o(seg_dram)
    );

    // Register aliases
    wire cfg_byte_t r_tag = cfg.regs[0];
    wire cfg_byte_t r_cyc = cfg.regs[1];
    wire cfg_byte_t r_dec = cfg.regs[3];
    wire cfg_byte_t r_sh1 = cfg.regs[4];
    wire cfg_byte_t r_edo = cfg.regs[6];
    wire cfg_byte_t r_misc = cfg.regs[7];
    wire cfg_byte_t r_brg = cfg.regs[8];
    wire cfg_byte_t r_edt = cfg.regs[9];

    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // Tag and leadoff decode
    wire logic tag7_d = r_tag[`BIT_TAG_7BIT];
    wire logic [2:0] leadoff_d = r_tag[`BIT_WHIT_FAST] ? `LEADOFF_FAST
                                                        : `LEADOFF_SLOW;

    // Pre-snoop qualification
    wire logic on_line = (snoop_addr_i[LINE_BITS-1:0] == '0);
    wire logic snoop_ok = r_tag[`BIT_PRESNOOP_ALL] ? !on_line
                                                   : (snoop_addr_i == 32'h0);
    wire logic presnoop_d = snoop_start_i && snoop_ok;

    // Host data output enable
    wire logic host_data_out_enable_d = host_cycle_active_i &&
                        !(r_tag[`BIT_HOST_DATA_OUT_ENABLE_EARLY] && host_cycle_last_clk_i);

    // Next address request
    wire logic pci_async = !r_tag[`BIT_PCI_BUS_CLOCK_SYNC];
    wire logic na_d = r_cyc[`BIT_NA_PCI_SLAVE] && pci_async && cpu_pci_slave_access_i;

    // Bank 4 and shared pin
    wire logic [2:0] b4_size = r_dec[2:0];
    wire logic b4_pop = r_dec[`BIT_BANK4_EN] && (b4_size != 3'h0);
    wire logic pin_row5 = r_dec[`BIT_PIN_ROW5];

    // EDO decode
    wire logic [5:0] edo_banks = r_edo[7:2];
    wire logic bank_edo = (burst_bank_i <= 3'h5) && edo_banks[burst_bank_i];
    wire logic cas1_d = r_edo[`BIT_CAS_ONE_CLK] && cpu_read_burst_i && bank_edo;
    wire logic fpm222_d = r_edo[`BIT_SLOW_FPM_222];

    // SMM routing of A and B segments
    wire logic in_a = (mem_addr_i[19:16] == 4'ha);
    wire logic in_b = (mem_addr_i[19:16] == 4'hb);
    wire logic smm_pci_d = smm_active_i &&
                           ((in_a && r_misc[`BIT_SMM_A_PCI]) ||
                            (in_b && r_misc[`BIT_SMM_B_PCI]));

    // Bridge and PCI behaviour
    wire logic trdy_d = pci_master_read_i &&
                        (pci_irdy_i || r_brg[`BIT_TRDY_NO_IRDY]);
    wire logic hi_range = in_range(pci_retry_addr_i, 32'h0008_0000, 32'h000f_ffff);
    wire logic cpu_back_off_dead = r_brg[`BIT_DEADLOCK_CPU_BACK_OFF] && bridge_deadlock_i;
    wire logic cpu_back_off_hi = r_brg[`BIT_BACKOFF_HI] && r_brg[`BIT_DEADLOCK_CPU_BACK_OFF] &&
                         pci_retry_i && hi_range;
    wire logic be_mixed = (host_be_n_i[7:4] != 4'h0) || (host_be_n_i[3:0] != 4'h0);
    wire logic burst_off_d = r_brg[`BIT_BURST_BE_OFF] && be_mixed;
    wire logic d_cache_d = r_edt[`BIT_D_CACHEABLE] && (mem_addr_i[19:16] == 4'hd);

    // CPU bandwidth guarantee window
    localparam int WIN_CYC = `BW_WINDOW_CYC;
    logic [10:0] win_cnt_q;
    logic [10:0] win_cnt_d;
    logic [10:0] guard_len;
    always_comb begin
        case (r_sh1[6:5])
            2'b01: guard_len = 11'(`BW_1US_CYC);
            2'b10: guard_len = 11'(`BW_2US_CYC);
            2'b11: guard_len = 11'(`BW_4US_CYC);
            default: guard_len = 11'h0;
        endcase
    end
    assign win_cnt_d = (win_cnt_q == 11'(WIN_CYC - 1)) ? 11'h0 : win_cnt_q + 11'h1;
    wire logic guard_d = (win_cnt_q < guard_len);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            win_cnt_q <= 11'h0;
        end else begin
            win_cnt_q <= win_cnt_d;
        end
    end

    // Registered control outputs
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tag_is_7bit_o <= 1'b1;
            cache_chip_select_pin_en_o <= 1'b1;
            dirty_pin_en_o <= 1'b0;
            write_hit_leadoff_o <= `LEADOFF_SLOW;
            presnoop_req_o <= 1'b0;
            host_data_out_enable_o <= 1'b0;
            linear_burst_o <= 1'b0;
            pci_clock_sync_o <= 1'b0;
            next_address_request_o <= 1'b0;
            bank4_enable_o <= 1'b0;
            bank4_size_o <= 3'h0;
            bank4_populated_o <= 1'b0;
            pin_is_row_strobe_bank_five_o <= 1'b0;
            global_write_enable_pin_en_o <= 1'b1;
            cpu_bus_guaranteed_o <= 1'b0;
            shadow_fine_8k_o <= 1'b0;
            shadow_seg_hit_o <= 1'b0;
            shadow_to_dram_o <= 1'b0;
            bank_is_edo_o <= 6'h0;
            cas_one_clk_o <= 1'b0;
            fpm_fast_burst_o <= 1'b0;
            smm_route_to_pci_o <= 1'b0;
            dma_from_memory_blocked_o <= 1'b0;
            dram_leadoff_cut_o <= 1'b0;
            pci_trdy_allowed_o <= 1'b0;
            cpu_back_off_o <= 1'b0;
            pci_burst_disable_o <= 1'b0;
            d_region_cacheable_o <= 1'b0;
        end else begin
            tag_is_7bit_o <= tag7_d;
            cache_chip_select_pin_en_o <= tag7_d;
            dirty_pin_en_o <= !tag7_d;
            write_hit_leadoff_o <= leadoff_d;
            presnoop_req_o <= presnoop_d;
            host_data_out_enable_o <= host_data_out_enable_d;
            linear_burst_o <= r_cyc[`BIT_LINEAR_BURST];
            pci_clock_sync_o <= !pci_async;
            next_address_request_o <= na_d;
            bank4_enable_o <= r_dec[`BIT_BANK4_EN];
            bank4_size_o <= b4_size;
            bank4_populated_o <= b4_pop;
            pin_is_row_strobe_bank_five_o <= pin_row5;
            global_write_enable_pin_en_o <= !pin_row5;
            cpu_bus_guaranteed_o <= guard_d;
            shadow_fine_8k_o <= r_sh1[`BIT_FINE_8K];
            shadow_seg_hit_o <= seg_hit;
            shadow_to_dram_o <= seg_dram;
            bank_is_edo_o <= edo_banks;
            cas_one_clk_o <= cas1_d;
            fpm_fast_burst_o <= fpm222_d;
            smm_route_to_pci_o <= smm_pci_d;
            dma_from_memory_blocked_o <= r_misc[`BIT_DMA_BLOCK];
            dram_leadoff_cut_o <= r_misc[`BIT_LEADOFF_CUT];
            pci_trdy_allowed_o <= trdy_d;
            cpu_back_off_o <= cpu_back_off_dead || cpu_back_off_hi;
            pci_burst_disable_o <= burst_off_d;
            d_region_cacheable_o <= d_cache_d;
        end
    end
endmodule : system_config_regs_16_to_1f

// file: rtl/sysconf_defs.svh
// Offsets, reset values, masks and timing figures of the config bank
`ifndef SYSCONF_DEFS_SVH
`define SYSCONF_DEFS_SVH
`define OFS_DIRTY_TAG 8'h16
`define OFS_PCI_CYC2 8'h17
`define OFS_IFACE_DRIVE 8'h18
`define OFS_MEM_DEC3 8'h19
`define OFS_SHADOW1 8'h1a
`define OFS_SHADOW2 8'h1b
`define OFS_EDO_CTRL 8'h1c
`define OFS_MISC3 8'h1d
`define OFS_BRIDGE 8'h1e
`define OFS_EDO_TIMING 8'h1f
`define OFS_FIRST 8'h16
`define NUM_REGS 10
`define RST_DIRTY_TAG 8'ha0
`define RST_ZERO 8'h00
`define MASK_DIRTY_TAG 8'hbd
`define MASK_PCI_CYC2 8'h67
`define MASK_IFACE_DRIVE 8'h70
`define MASK_BRIDGE 8'hfe
`define MASK_EDO_TIMING 8'hf7
`define MASK_FULL 8'hff
`define BIT_TAG_7BIT 5
`define BIT_WHIT_FAST 4
`define BIT_PRESNOOP_ALL 3
`define BIT_PCI_BUS_CLOCK_SYNC 2
`define BIT_HOST_DATA_OUT_ENABLE_EARLY 0
`define BIT_LINEAR_BURST 0
`define BIT_NA_PCI_SLAVE 6
`define BIT_PIN_ROW5 7
`define BIT_BANK4_EN 3
`define BIT_FINE_8K 4
`define BIT_CAS_ONE_CLK 0
`define BIT_SLOW_FPM_222 1
`define BIT_SMM_A_PCI 1
`define BIT_SMM_B_PCI 0
`define BIT_DMA_BLOCK 3
`define BIT_LEADOFF_CUT 4
`define BIT_TRDY_NO_IRDY 7
`define BIT_BACKOFF_HI 4
`define BIT_DEADLOCK_CPU_BACK_OFF 3
`define BIT_BURST_BE_OFF 1
`define BIT_D_CACHEABLE 0
`define LEADOFF_SLOW 3'd5
`define LEADOFF_FAST 3'd4
`define CLK_PERIOD_NS 10
`define BW_WINDOW_NS 15000
`define BW_WINDOW_CYC (`BW_WINDOW_NS / `CLK_PERIOD_NS)
`define BW_1US_CYC (1000 / `CLK_PERIOD_NS)
`define BW_2US_CYC (2000 / `CLK_PERIOD_NS)
`define BW_4US_CYC (4000 / `CLK_PERIOD_NS)
`endif

// file: rtl/sysconf_pkg.sv
// Types shared by the configuration bank modules
package sysconf_pkg;
    typedef enum logic [1:0] {
        ROUTE_PCI_BOTH,
        ROUTE_RD_DRAM_WR_PCI,
        ROUTE_RD_PCI_WR_DRAM,
        ROUTE_DRAM_BOTH
    } shadow_route_e;
    typedef logic [7:0] cfg_byte_t;
endpackage : sysconf_pkg

// file: rtl/cfg_if.sv
// Register contents passed from storage to the decoders
`timescale 1ns/1ps
`include "sysconf_defs.svh"
interface cfg_if;
    import sysconf_pkg::*;
    cfg_byte_t regs [`NUM_REGS];
    modport store (output regs);
    modport use_side (input regs);
endinterface : cfg_if

// file: rtl/cfg_store.sv
// Register storage with write masking and one-cycle read data
`timescale 1ns/1ps
`include "sysconf_defs.svh"
module cfg_store
    import sysconf_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [7:0] rdata_o,
    // Stored values
    cfg_if.store cfg
);
    cfg_byte_t mask [`NUM_REGS];
    wire logic hit = (addr_i >= `OFS_FIRST) && (addr_i <= `OFS_EDO_TIMING);
    wire logic [3:0] idx = 4'(addr_i - `OFS_FIRST);
    always_comb begin
        for (int i = 0; i < `NUM_REGS; i++) begin
            mask[i] = `MASK_FULL;
        end
        mask[0] = `MASK_DIRTY_TAG;
        mask[1] = `MASK_PCI_CYC2;
        mask[2] = `MASK_IFACE_DRIVE;
        mask[8] = `MASK_BRIDGE;
        mask[9] = `MASK_EDO_TIMING;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < `NUM_REGS; i++) begin
                cfg.regs[i] <= (i == 0) ? `RST_DIRTY_TAG : `RST_ZERO;
            end
            rdata_o <= `RST_ZERO;
        end else begin
            if (we_i && hit) begin
                cfg.regs[idx] <= wdata_i & mask[idx];
            end
            rdata_o <= (re_i && hit) ? (cfg.regs[idx] & mask[idx]) : `RST_ZERO;
        end
    end
endmodule : cfg_store

// file: rtl/shadow_route.sv
// Routing of the fine-grained 8KB shadow segments
`timescale 1ns/1ps
`include "sysconf_defs.svh"
module shadow_route
    import sysconf_pkg::*;
(
    // Register values
    cfg_if.use_side cfg,
    // Access
    input wire logic [19:13] seg_addr_i,
    input wire logic is_write_i,
    // Result
    output logic seg_hit_o,
    output logic to_dram_o
);
    function automatic logic route_dram(input logic [1:0] f, input logic wr);
        shadow_route_e r;
        r = shadow_route_e'(f);
        case (r)
            ROUTE_PCI_BOTH: route_dram = 1'b0;
            ROUTE_RD_DRAM_WR_PCI: route_dram = !wr;
            ROUTE_RD_PCI_WR_DRAM: route_dram = wr;
            default: route_dram = 1'b1;
        endcase
    endfunction : route_dram
    logic [1:0] field;
    logic known;
    always_comb begin
        field = 2'b00;
        known = 1'b1;
        case (seg_addr_i)
            7'h65: field = cfg.regs[4][1:0];
            7'h67: field = cfg.regs[4][3:2];
            7'h69: field = cfg.regs[5][1:0];
            7'h6b: field = cfg.regs[5][3:2];
            7'h6d: field = cfg.regs[5][5:4];
            7'h6f: field = cfg.regs[5][7:6];
            default: known = 1'b0;
        endcase
    end
    assign seg_hit_o = known && cfg.regs[4][`BIT_FINE_8K];
    assign to_dram_o = seg_hit_o && route_dram(field, is_write_i);
endmodule : shadow_route

// file: test/sysconf_monitor.sv
// Port assertions for the configuration bank
`timescale 1ns/1ps
module sysconf_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    input wire logic [7:0] rdata_o,
    // Watched controls
    input wire logic tag_is_7bit_o,
    input wire logic cache_chip_select_pin_en_o,
    input wire logic dirty_pin_en_o,
    input wire logic [2:0] write_hit_leadoff_o,
    input wire logic cpu_pci_slave_access_i,
    input wire logic pci_clock_sync_o,
    input wire logic next_address_request_o,
    input wire logic cpu_bus_guaranteed_o,
    input wire logic pci_master_read_i,
    input wire logic pci_trdy_allowed_o,
    input wire logic [7:0] host_be_n_i,
    input wire logic pci_burst_disable_o
);
    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Length of the current guaranteed run
    logic [10:0] run_q;
    logic [10:0] run_d;
    assign run_d = cpu_bus_guaranteed_o ? run_q + 11'h001 : 11'h000;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_q <= 11'h000;
        end else begin
            run_q <= run_d;
        end
    end
    sequence s_fast_wr;
        we_i && addr_i == 8'h16 && wdata_i[4] ##1 !(we_i && addr_i == 8'h16);
    endsequence
    sequence s_slow_wr;
        we_i && addr_i == 8'h16 && !wdata_i[4] ##1 !(we_i && addr_i == 8'h16);
    endsequence
    a_read_idle_zero: assert property (
        !(re_i && addr_i inside {[8'h16:8'h1f]}) |=> rdata_o == 8'h00)
        else $error("read data not zero");
    a_tag_pin_pick: assert property (
        cache_chip_select_pin_en_o == tag_is_7bit_o && dirty_pin_en_o == !tag_is_7bit_o)
        else $error("tag pin choice wrong");
    a_leadoff_four: assert property (s_fast_wr |=> write_hit_leadoff_o == 3'h4)
        else $error("leadoff not four");
    a_leadoff_five: assert property (s_slow_wr |=> write_hit_leadoff_o == 3'h5)
        else $error("leadoff not five");
    a_next_addr_async: assert property (
        next_address_request_o |-> !pci_clock_sync_o && $past(cpu_pci_slave_access_i))
        else $error("next address without cause");
    a_guarantee_max: assert property (cpu_bus_guaranteed_o |-> run_q < 11'h190)
        else $error("guarantee run too long");
    a_trdy_on_read: assert property (pci_trdy_allowed_o |-> $past(pci_master_read_i))
        else $error("target ready without read");
    a_burst_off_be: assert property (
        pci_burst_disable_o |-> $past(host_be_n_i) != 8'h00)
        else $error("burst disabled with zero enables");
endmodule : sysconf_monitor
bind system_config_regs_16_to_1f sysconf_monitor mon (.*);

// file: test/tb.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
`include "sysconf_defs.svh"
module tb;
    import sysconf_pkg::*;
    // Driven inputs
    logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, re_i = 1'b0, snoop_start_i = 1'b0;
    logic host_cycle_active_i = 1'b0, host_cycle_last_clk_i = 1'b0, mem_write_i = 1'b0;
    logic cpu_pci_slave_access_i = 1'b0, cpu_read_burst_i = 1'b0, smm_active_i = 1'b0;
    logic pci_master_read_i = 1'b0, pci_irdy_i = 1'b0, bridge_deadlock_i = 1'b0;
    logic pci_retry_i = 1'b0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, host_be_n_i = 8'h00;
    logic [31:0] snoop_addr_i = 32'h0, pci_retry_addr_i = 32'h0;
    logic [19:0] mem_addr_i = 20'h0;
    logic [2:0] burst_bank_i = 3'h0;
    // Observed outputs
    logic [7:0] rdata_o;
    logic [2:0] write_hit_leadoff_o, bank4_size_o;
    logic [5:0] bank_is_edo_o;
    logic tag_is_7bit_o, cache_chip_select_pin_en_o, dirty_pin_en_o, presnoop_req_o;
    logic host_data_out_enable_o, linear_burst_o, pci_clock_sync_o, next_address_request_o;
    logic bank4_enable_o, bank4_populated_o, pin_is_row_strobe_bank_five_o;
    logic global_write_enable_pin_en_o, cpu_bus_guaranteed_o, shadow_fine_8k_o;
    logic shadow_seg_hit_o, shadow_to_dram_o, cas_one_clk_o, fpm_fast_burst_o;
    logic smm_route_to_pci_o, dma_from_memory_blocked_o, dram_leadoff_cut_o;
    logic pci_trdy_allowed_o, cpu_back_off_o, pci_burst_disable_o, d_region_cacheable_o;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    system_config_regs_16_to_1f dut (.*);
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fails++;
            finish_test;
        end
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic st;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : st
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i <= 1'b0;
        st;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        re_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1;
        chk($sformatf("rdata %h", a), e, rdata_o);
        @(posedge clk_i);
        #1;
        chk("rdata after", 8'h00, rdata_o);
    endtask : rd
    task automatic t_regs;
        logic [7:0] m [10];
        m = '{`MASK_DIRTY_TAG, `MASK_PCI_CYC2, `MASK_IFACE_DRIVE, `MASK_FULL, `MASK_FULL,
              `MASK_FULL, `MASK_FULL, `MASK_FULL, `MASK_BRIDGE, `MASK_EDO_TIMING};
        chk("tag7 reset", 1'b1, tag_is_7bit_o);
        chk("leadoff reset", 3'h5, write_hit_leadoff_o);
        chk("gwe reset", 1'b1, global_write_enable_pin_en_o);
        for (int i = 0; i < 10; i++) begin
            rd(8'h16 + 8'(i), (i == 0) ? `RST_DIRTY_TAG : `RST_ZERO);
        end
        for (int i = 0; i < 10; i++) begin
            wr(8'h16 + 8'(i), 8'hff);
            rd(8'h16 + 8'(i), m[i]);
            wr(8'h16 + 8'(i), 8'h5a);
            rd(8'h16 + 8'(i), 8'h5a & m[i]);
        end
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h00);
        rd(8'h15, 8'h00);
        $display("regs test done");
    endtask : t_regs
    task automatic snp(input logic [31:0] a, input logic e);
        @(posedge clk_i);
        snoop_start_i <= 1'b1;
        snoop_addr_i <= a;
        st;
        chk("presnoop", e, presnoop_req_o);
    endtask : snp
    task automatic hd(input logic last, input logic e);
        @(posedge clk_i);
        host_cycle_active_i <= 1'b1;
        host_cycle_last_clk_i <= last;
        st;
        chk("host data oe", e, host_data_out_enable_o);
    endtask : hd
    task automatic t_tag;
        wr(`OFS_DIRTY_TAG, 8'h19);
        chk("tag7", 1'b0, tag_is_7bit_o);
        chk("dirty pin", 1'b1, dirty_pin_en_o);
        chk("cache cs pin", 1'b0, cache_chip_select_pin_en_o);
        chk("leadoff", 3'h4, write_hit_leadoff_o);
        snp(32'h20, 1'b0);
        snp(32'h24, 1'b1);
        hd(1'b1, 1'b0);
        hd(1'b0, 1'b1);
        wr(`OFS_DIRTY_TAG, 8'h00);
        snp(32'h0, 1'b1);
        snp(32'h24, 1'b0);
        hd(1'b1, 1'b1);
        @(posedge clk_i);
        cpu_pci_slave_access_i <= 1'b1;
        wr(`OFS_PCI_CYC2, 8'h41);
        chk("linear", 1'b1, linear_burst_o);
        chk("next addr", 1'b1, next_address_request_o);
        wr(`OFS_DIRTY_TAG, 8'h04);
        chk("next addr sync", 1'b0, next_address_request_o);
        chk("pci sync", 1'b1, pci_clock_sync_o);
        wr(`OFS_PCI_CYC2, 8'h00);
        chk("interleaved", 1'b0, linear_burst_o);
        wr(`OFS_MEM_DEC3, 8'h8d);
        chk("bank4 size", 3'h5, bank4_size_o);
        chk("bank4 pop", 1'b1, bank4_populated_o);
        chk("bank4 en", 1'b1, bank4_enable_o);
        chk("row5 pin", 1'b1, pin_is_row_strobe_bank_five_o);
        wr(`OFS_MEM_DEC3, 8'h08);
        chk("bank4 empty", 1'b0, bank4_populated_o);
        chk("gwe pin", 1'b1, global_write_enable_pin_en_o);
        $display("tag test done");
    endtask : t_tag
    task automatic t_bw;
        int n;
        for (int c = 0; c < 4; c++) begin
            wr(`OFS_SHADOW1, 8'(c << 5));
            repeat (1500) @(posedge clk_i);
            n = 0;
            repeat (1500) begin
                @(posedge clk_i);
                #1;
                n += (cpu_bus_guaranteed_o === 1'b1) ? 1 : 0;
            end
            chk("guarantee", (c == 0) ? 0 : (`BW_1US_CYC << (c - 1)), n);
        end
        $display("bandwidth test done");
    endtask : t_bw
    task automatic mem(input logic [19:0] a, input logic w);
        @(posedge clk_i);
        mem_addr_i <= a;
        mem_write_i <= w;
        smm_active_i <= 1'b1;
        st;
    endtask : mem
    task automatic t_mem;
        for (int c = 0; c < 4; c++) begin
            wr(`OFS_SHADOW1, 8'h10 | 8'(c));
            mem(20'hca000, 1'b0);
            chk("seg hit", 1'b1, shadow_seg_hit_o);
            chk("fine 8k", 1'b1, shadow_fine_8k_o);
            chk("read route", c[0], shadow_to_dram_o);
            mem(20'hca000, 1'b1);
            chk("write route", c[1], shadow_to_dram_o);
        end
        wr(`OFS_SHADOW1, 8'h03);
        chk("coarse hit", 1'b0, shadow_seg_hit_o);
        wr(`OFS_MISC3, 8'h1a);
        chk("dma block", 1'b1, dma_from_memory_blocked_o);
        chk("leadoff cut", 1'b1, dram_leadoff_cut_o);
        mem(20'ha0000, 1'b0);
        chk("smm a", 1'b1, smm_route_to_pci_o);
        mem(20'hb0000, 1'b0);
        chk("smm b", 1'b0, smm_route_to_pci_o);
        wr(`OFS_MISC3, 8'h01);
        chk("smm b set", 1'b1, smm_route_to_pci_o);
        chk("dma open", 1'b0, dma_from_memory_blocked_o);
        mem(20'hd1234, 1'b0);
        chk("d region off", 1'b0, d_region_cacheable_o);
        wr(`OFS_EDO_TIMING, 8'h01);
        chk("d region on", 1'b1, d_region_cacheable_o);
        $display("memory test done");
    endtask : t_mem
    task automatic t_edo;
        @(posedge clk_i);
        cpu_read_burst_i <= 1'b1;
        burst_bank_i <= 3'h1;
        wr(`OFS_EDO_CTRL, 8'h0d);
        chk("edo banks", 6'h03, bank_is_edo_o);
        chk("cas edo", 1'b1, cas_one_clk_o);
        @(posedge clk_i);
        burst_bank_i <= 3'h2;
        st;
        chk("cas fpm", 1'b0, cas_one_clk_o);
        wr(`OFS_EDO_CTRL, 8'h02);
        chk("fpm fast", 1'b1, fpm_fast_burst_o);
        $display("edo test done");
    endtask : t_edo
    task automatic bo(input logic [7:0] r, input logic [31:0] a, input logic t, input logic e);
        @(posedge clk_i);
        pci_retry_i <= t;
        bridge_deadlock_i <= !t;
        pci_retry_addr_i <= a;
        wr(`OFS_BRIDGE, r);
        chk("back off", e, cpu_back_off_o);
    endtask : bo
    task automatic t_bridge;
        @(posedge clk_i);
        pci_master_read_i <= 1'b1;
        host_be_n_i <= 8'h10;
        wr(`OFS_BRIDGE, 8'h02);
        chk("trdy wait", 1'b0, pci_trdy_allowed_o);
        @(posedge clk_i);
        pci_irdy_i <= 1'b1;
        st;
        chk("trdy irdy", 1'b1, pci_trdy_allowed_o);
        @(posedge clk_i);
        pci_irdy_i <= 1'b0;
        chk("burst off", 1'b1, pci_burst_disable_o);
        wr(`OFS_BRIDGE, 8'h80);
        chk("trdy no wait", 1'b1, pci_trdy_allowed_o);
        chk("burst on", 1'b0, pci_burst_disable_o);
        bo(8'h10, 32'h9_0000, 1'b1, 1'b0);
        bo(8'h18, 32'h8_0000, 1'b1, 1'b1);
        bo(8'h18, 32'hf_ffff, 1'b1, 1'b1);
        bo(8'h18, 32'h10_0000, 1'b1, 1'b0);
        bo(8'h08, 32'h9_0000, 1'b0, 1'b1);
        bo(8'h10, 32'h9_0000, 1'b0, 1'b0);
        $display("bridge test done");
    endtask : t_bridge
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        st;
        t_regs;
        t_tag;
        t_bw;
        t_mem;
        t_edo;
        t_bridge;
        finish_test;
    end
endmodule : tb
